// >>> rtl/isi_defs.svh
// Register offsets, field positions and reset values of the two-wire slave.
`ifndef ISI_DEFS_SVH
`define ISI_DEFS_SVH

`define ISI_OFS_CTRL0      8'h00
`define ISI_OFS_CTRL1      8'h04
`define ISI_OFS_DATA       8'h08
`define ISI_OFS_ADDR       8'h0c
`define ISI_OFS_SUBC       8'h10

`define ISI_C0_MODE_HI     7
`define ISI_C0_MODE_LO     5
`define ISI_C0_UNIT_EN     1
`define ISI_C0_IRQ_EN      0
`define ISI_MODE_TWO_WIRE  3'h7

`define ISI_C1_DONE        7
`define ISI_C1_HIT         6
`define ISI_C1_BUSY        5
`define ISI_C1_HTX         4
`define ISI_C1_TX_ACK_BIT        3
`define ISI_C1_DIR         2
`define ISI_C1_WAKE_EN     1
`define ISI_C1_RX_ACK_FLAG        0

`define ISI_SC_WCOL_HI     7
`define ISI_SC_DB_HI       5
`define ISI_SC_DB_LO       4
`define ISI_SC_WCOL_LO     0
`define ISI_SC_RW_MASK     8'hb1

`define ISI_RST_CTRL0      8'h00
`define ISI_RST_DATA       8'h00
`define ISI_RST_ADDR       8'h00
`define ISI_RST_SUBC       8'h00
`define ISI_RST_DONE       1'b1
`define ISI_RST_RX_ACK_FLAG       1'b1

`define ISI_BITS_PER_BYTE  4'h8
`define ISI_RESP_OKAY      2'h0
`define ISI_RESP_SLVERR    2'h2

`endif

// >>> rtl/isi_pkg.sv
// Types shared by the two-wire slave interface.
package isi_pkg;
  typedef enum logic [3:0] {
    ISI_IDLE,
    ISI_ADDR,
    ISI_AACK,
    ISI_HOLD,
    ISI_RX,
    ISI_RACK,
    ISI_TX,
    ISI_TACK,
    ISI_SKIP
  } isi_state_t;
  typedef logic [7:0] isi_byte_t;
endpackage

// >>> rtl/isi_top.sv
// Two-wire bus slave with AXI4-Lite register access.
`timescale 1ns/10ps
`include "isi_defs.svh"

module isi_top (
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             serial_irq,
  output logic             wake_req
);
  import isi_pkg::*;

  isi_byte_t  ctrl0;
  isi_byte_t  serial_data_buffer;
  isi_byte_t  own_slave_address;
  isi_byte_t  serial_bus_sub_control;
  logic       tx_ack_bit;
  logic       htx;
  logic       addr_match_wake_en;
  logic       transfer_done_flag;
  logic       address_hit_flag;
  logic       bus_busy_flag;
  logic       master_direction_flag;
  logic       rx_ack_flag;
  isi_state_t state;
  logic [3:0] bit_cnt;
  isi_byte_t  shreg;
  logic       rx_load;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic       aw_held;
  logic       w_held;
  logic       wr_go;
  logic       wr_data_buf;
  logic       rd_data_buf;
  logic [1:0] line_s1;
  logic [1:0] line_s2;
  logic [1:0] line_h1;
  logic [1:0] line_f;
  logic [1:0] line_fd;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       unit_on;
  logic [1:0] db_sel;
  isi_byte_t  ctrl1;
  isi_byte_t  rd_val;
  logic       rd_hit;

  assign unit_on = ctrl0[`ISI_C0_UNIT_EN] &&
                   (ctrl0[`ISI_C0_MODE_HI:`ISI_C0_MODE_LO] == `ISI_MODE_TWO_WIRE);
  assign db_sel  = serial_bus_sub_control[`ISI_SC_DB_HI:`ISI_SC_DB_LO];
  assign ctrl1   = {transfer_done_flag, address_hit_flag, bus_busy_flag, htx,
                    tx_ack_bit, master_direction_flag, addr_match_wake_en, rx_ack_flag};

  // Bit 1 is SCL, bit 0 is SDA. The first stage feeds only the second.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      line_s1 <= 2'h3;
      line_s2 <= 2'h3;
    end else begin
      line_s1 <= {scl_i, sda_i};
      line_s2 <= line_s1;
    end
  end

  // With any nonzero setting a new level is accepted once two successive samples agree; setting 0 passes it at once.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      line_h1 <= 2'h3;
      line_f  <= 2'h3;
      line_fd <= 2'h3;
    end else begin
      line_h1 <= line_s2;
      line_fd <= line_f;
      for (int i = 0; i < 2; i++) begin
        if (db_sel == 2'h0) begin
          line_f[i] <= line_s2[i];
        end else if (db_sel == 2'h1) begin
          if (line_s2[i] == line_h1[i]) begin
            line_f[i] <= line_s2[i];
          end
        end else if ((line_s2[i] == line_h1[i]) && (line_h1[i] != line_f[i])) begin
          line_f[i] <= line_h1[i];
        end
      end
    end
  end

  assign scl_rise  = line_f[1] && !line_fd[1];
  assign scl_fall  = !line_f[1] && line_fd[1];
  assign start_det = line_f[1] && line_fd[1] && !line_f[0] && line_fd[0];
  assign stop_det  = line_f[1] && line_fd[1] && line_f[0] && !line_fd[0];

  // Open-drain pins: the output level is always low, only the enables move.
  // SCL is only ever stretched low and SDA never falls while SCL is high,
  // so this end cannot create a START of its own.
  always_ff @(posedge mclk) begin
    scl_o <= 1'b0;
    sda_o <= 1'b0;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst || !unit_on) begin
      state                 <= ISI_IDLE;
      bit_cnt               <= 4'h0;
      shreg                 <= 8'h00;
      scl_oe                <= 1'b0;
      sda_oe                <= 1'b0;
      transfer_done_flag    <= `ISI_RST_DONE;
      address_hit_flag      <= 1'b0;
      bus_busy_flag         <= 1'b0;
      master_direction_flag <= 1'b0;
      rx_ack_flag           <= `ISI_RST_RX_ACK_FLAG;
      rx_load               <= 1'b0;
      serial_irq            <= 1'b0;
      wake_req              <= 1'b0;
    end else begin
      rx_load    <= 1'b0;
      serial_irq <= 1'b0;
      wake_req   <= 1'b0;
      if (start_det) begin
        bus_busy_flag      <= 1'b1;
        transfer_done_flag <= 1'b0;
        address_hit_flag   <= 1'b0;
        scl_oe             <= 1'b0;
        sda_oe             <= 1'b0;
        bit_cnt            <= 4'h0;
        state              <= ISI_ADDR;
      end else if (stop_det) begin
        bus_busy_flag <= 1'b0;
        scl_oe        <= 1'b0;
        sda_oe        <= 1'b0;
        state         <= ISI_IDLE;
      end else begin
        case (state)
          ISI_ADDR: begin
            if (scl_rise) begin
              shreg   <= {shreg[6:0], line_f[0]};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == `ISI_BITS_PER_BYTE) begin
              if (shreg[7:1] == own_slave_address[7:1]) begin
                address_hit_flag      <= 1'b1;
                master_direction_flag <= shreg[0];
                sda_oe                <= 1'b1;
                state                 <= ISI_AACK;
              end else begin
                state <= ISI_SKIP;
              end
            end
          end
          ISI_AACK: begin
            if (scl_fall) begin
              sda_oe             <= 1'b0;
              scl_oe             <= 1'b1;
              transfer_done_flag <= 1'b1;
              serial_irq         <= ctrl0[`ISI_C0_IRQ_EN];
              wake_req           <= addr_match_wake_en;
              state              <= ISI_HOLD;
            end
          end
          ISI_HOLD: begin
            // Releasing SCL waits for software: a write when sending, a dummy read otherwise.
            if (htx && wr_data_buf) begin
              scl_oe             <= 1'b0;
              shreg              <= {w_data[6:0], 1'b0};
              sda_oe             <= !w_data[7];
              bit_cnt            <= 4'h1;
              address_hit_flag   <= 1'b0;
              transfer_done_flag <= 1'b0;
              state              <= ISI_TX;
            end else if (!htx && rd_data_buf) begin
              scl_oe             <= 1'b0;
              bit_cnt            <= 4'h0;
              address_hit_flag   <= 1'b0;
              transfer_done_flag <= 1'b0;
              state              <= ISI_RX;
            end
          end
          ISI_RX: begin
            if (scl_rise) begin
              shreg   <= {shreg[6:0], line_f[0]};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == `ISI_BITS_PER_BYTE) begin
              rx_load <= 1'b1;
              sda_oe  <= !tx_ack_bit;
              state   <= ISI_RACK;
            end
          end
          ISI_RACK: begin
            if (scl_fall) begin
              sda_oe             <= 1'b0;
              scl_oe             <= 1'b1;
              transfer_done_flag <= 1'b1;
              serial_irq         <= ctrl0[`ISI_C0_IRQ_EN];
              state              <= ISI_HOLD;
            end
          end
          ISI_TX: begin
            if (scl_fall) begin
              if (bit_cnt == `ISI_BITS_PER_BYTE) begin
                sda_oe <= 1'b0;
                state  <= ISI_TACK;
              end else begin
                sda_oe  <= !shreg[7];
                shreg   <= {shreg[6:0], 1'b0};
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          ISI_TACK: begin
            if (scl_rise) begin
              rx_ack_flag <= line_f[0];
            end else if (scl_fall) begin
              transfer_done_flag <= 1'b1;
              serial_irq         <= ctrl0[`ISI_C0_IRQ_EN];
              if (!rx_ack_flag) begin
                scl_oe <= 1'b1;
                state  <= ISI_HOLD;
              end else begin
                state <= ISI_SKIP;
              end
            end
          end
          default: begin
            state <= state;
          end
        endcase
      end
    end
  end

  // AXI4-Lite write channel: address and data are taken in either order.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `ISI_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        aw_held       <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        w_held       <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == `ISI_OFS_CTRL0 || aw_addr == `ISI_OFS_CTRL1 ||
            aw_addr == `ISI_OFS_DATA || aw_addr == `ISI_OFS_ADDR ||
            aw_addr == `ISI_OFS_SUBC) begin
          s_axi_bresp <= `ISI_RESP_OKAY;
        end else begin
          s_axi_bresp <= `ISI_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  assign wr_go       = aw_held && w_held && !s_axi_bvalid;
  assign wr_data_buf = wr_go && w_strb[0] && (aw_addr == `ISI_OFS_DATA);

  // Writable control state; status bits are owned by the bus engine above.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl0                  <= `ISI_RST_CTRL0;
      own_slave_address      <= `ISI_RST_ADDR;
      serial_bus_sub_control <= `ISI_RST_SUBC;
      htx                    <= 1'b0;
      tx_ack_bit             <= 1'b0;
      addr_match_wake_en     <= 1'b0;
    end else if (wr_go && w_strb[0]) begin
      if (aw_addr == `ISI_OFS_CTRL0) begin
        ctrl0 <= w_data[7:0];
      end else if (aw_addr == `ISI_OFS_CTRL1) begin
        htx                <= w_data[`ISI_C1_HTX];
        tx_ack_bit         <= w_data[`ISI_C1_TX_ACK_BIT];
        addr_match_wake_en <= w_data[`ISI_C1_WAKE_EN];
      end else if (aw_addr == `ISI_OFS_ADDR) begin
        own_slave_address <= w_data[7:0];
      end else if (aw_addr == `ISI_OFS_SUBC) begin
        serial_bus_sub_control <= w_data[7:0] & `ISI_SC_RW_MASK;
      end
    end
  end

  // A received byte has priority over a software write landing in the same cycle.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      serial_data_buffer <= `ISI_RST_DATA;
    end else if (rx_load) begin
      serial_data_buffer <= shreg;
    end else if (wr_data_buf) begin
      serial_data_buffer <= w_data[7:0];
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    rd_val = 8'h00;
    if (s_axi_araddr == `ISI_OFS_CTRL0) begin
      rd_val = ctrl0;
    end else if (s_axi_araddr == `ISI_OFS_CTRL1) begin
      rd_val = ctrl1;
    end else if (s_axi_araddr == `ISI_OFS_DATA) begin
      rd_val = serial_data_buffer;
    end else if (s_axi_araddr == `ISI_OFS_ADDR) begin
      rd_val = own_slave_address;
    end else if (s_axi_araddr == `ISI_OFS_SUBC) begin
      rd_val = serial_bus_sub_control;
    end else begin
      rd_hit = 1'b0;
    end
  end

  assign rd_data_buf = s_axi_arvalid && s_axi_arready && (s_axi_araddr == `ISI_OFS_DATA);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `ISI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h0, rd_val};
      s_axi_rresp   <= rd_hit ? `ISI_RESP_OKAY : `ISI_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// >>> sim/isi_checker.sv
// Port-level assertions for the two-wire slave and its register bus.
`timescale 1ns/10ps
module isi_checker (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        scl_i,
  input wire logic        scl_oe,
  input wire logic        sda_oe,
  input wire logic        serial_irq,
  input wire logic        wake_req
);
  logic [3:0] bus_hist;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // Only software may end a stretch, so a release must follow recent bus traffic.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bus_hist <= 4'h0;
    end else begin
      bus_hist <= {bus_hist[2:0], (s_axi_arvalid & s_axi_arready) | s_axi_rvalid |
                   (s_axi_wvalid & s_axi_wready) | s_axi_bvalid};
    end
  end
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data line moved while clock line high");
  a_stretch_free: assert property ($rose(scl_oe) |-> !sda_oe)
    else $error("clock stretch began with data line held");
  a_sw_release: assert property ($fell(scl_oe) |-> |bus_hist)
    else $error("clock stretch ended without software access");
  a_irq_pulse: assert property (serial_irq |=> !serial_irq)
    else $error("interrupt pulse longer than one cycle");
  a_wake_pulse: assert property (wake_req |=> !wake_req)
    else $error("wake pulse longer than one cycle");
  a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  // The response is registered one cycle after both halves are held.
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                                s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");
  a_wr_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted before response handshake");
endmodule

bind isi_top isi_checker i_isi_checker (.mclk, .sys_rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .scl_i, .scl_oe, .sda_oe, .serial_irq, .wake_req);

// >>> sim/isi_master_model.sv
// Behavioural two-wire bus master driving the slave from the far side.
`timescale 1ns/10ps
module isi_master_model (
  input  wire logic mclk,
  input  wire logic scl_line,
  input  wire logic sda_line,
  output logic      m_scl,
  output logic      m_sda
);
  localparam int HALF = 24;
  localparam int QTR  = 12;
  initial begin
    m_scl = 1'b1;
    m_sda = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Letting the clock go waits for the slave, so a stretch lengthens the bit.
  task automatic rise();
    m_scl <= 1'b1;
    tick(1);
    while (scl_line !== 1'b1) tick(1);
    tick(HALF);
  endtask
  task automatic clk_bit(input logic b, output logic s);
    m_sda <= b;
    tick(QTR);
    rise();
    s = sda_line;
    m_scl <= 1'b0;
    tick(QTR);
  endtask
  task automatic start();
    m_sda <= 1'b1;
    tick(QTR);
    rise();
    m_sda <= 1'b0;
    tick(HALF);
    m_scl <= 1'b0;
    tick(QTR);
  endtask
  task automatic stop();
    m_sda <= 1'b0;
    tick(QTR);
    rise();
    m_sda <= 1'b1;
    tick(HALF);
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
    clk_bit(1'b1, ack);
  endtask
  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, s);
      d[i] = s;
    end
    clk_bit(nack, s);
  endtask
endmodule

// >>> sim/i2c_slave_interface_tb_top.sv
// Self-checking bench: register access and two-wire transfers against a master model.
`timescale 1ns/10ps
`include "isi_defs.svh"
module i2c_slave_interface_tb_top;
  import isi_pkg::*;
  logic        mclk, sys_rst, m_scl, m_sda;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        scl_o, scl_oe, sda_o, sda_oe, serial_irq, wake_req;
  wire         scl_line = m_scl & ~scl_oe;
  wire         sda_line = m_sda & ~sda_oe;
  int          err_count, num_checks, irq_cnt, wake_cnt;
  isi_top i_isi_top (
    .mclk          (mclk),
    .sys_rst       (sys_rst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .scl_i         (scl_line),
    .scl_o         (scl_o),
    .scl_oe        (scl_oe),
    .sda_i         (sda_line),
    .sda_o         (sda_o),
    .sda_oe        (sda_oe),
    .serial_irq    (serial_irq),
    .wake_req      (wake_req)
  );
  isi_master_model i_isi_master_model (
    .mclk     (mclk),
    .scl_line (scl_line),
    .sda_line (sda_line),
    .m_scl    (m_scl),
    .m_sda    (m_sda)
  );
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (serial_irq === 1'b1) irq_cnt++;
    if (wake_req === 1'b1) wake_cnt++;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask
  // Waits as long as the slave needs; only the watchdog ends a hang.
  task automatic axi_wr(input logic [7:0] a, input isi_byte_t d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input isi_byte_t d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk("write resp", {30'h0, `ISI_RESP_OKAY}, {30'h0, r});
  endtask
  // Response code sits on top of the compare word so one check covers both.
  task automatic rdm(input logic [7:0] a, input isi_byte_t m, input isi_byte_t e, input string n);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk(n, {`ISI_RESP_OKAY, 22'h0, e}, {r, d[29:8], d[7:0] & m});
  endtask
  initial begin
    repeat (40000) @(posedge mclk);
    $display("mismatch watchdog expected done seen hang");
    err_count++;
    summarize();
  end
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic        ack;
    isi_byte_t   b;
    sys_rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata  = 32'h00000000;
    s_axi_wstrb  = 4'hf;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rdm(`ISI_OFS_CTRL0, 8'hff, `ISI_RST_CTRL0, "ctrl0 reset");
    rdm(`ISI_OFS_CTRL1, 8'hff, {`ISI_RST_DONE, 6'h00, `ISI_RST_RX_ACK_FLAG}, "ctrl1 reset");
    rdm(`ISI_OFS_DATA, 8'hff, `ISI_RST_DATA, "data reset");
    rdm(`ISI_OFS_ADDR, 8'hff, `ISI_RST_ADDR, "addr reset");
    rdm(`ISI_OFS_SUBC, 8'hff, `ISI_RST_SUBC, "subc reset");
    axi_rd(8'h14, d, r);
    chk("unmapped read", {`ISI_RESP_SLVERR, 30'h0}, {r, d[29:0]});
    axi_wr(8'h14, 8'hff, r);
    chk("unmapped write", {30'h0, `ISI_RESP_SLVERR}, {30'h0, r});
    wr(`ISI_OFS_SUBC, 8'hff);
    rdm(`ISI_OFS_SUBC, 8'hff, `ISI_SC_RW_MASK, "subc bits");
    wr(`ISI_OFS_ADDR, 8'ha4);
    rdm(`ISI_OFS_ADDR, 8'hff, 8'ha4, "own address");
    wr(`ISI_OFS_CTRL1, 8'hff);
    rdm(`ISI_OFS_CTRL1, 8'hff, 8'h9b, "ctrl1 access");
    wr(`ISI_OFS_CTRL0, 8'he2);
    wr(`ISI_OFS_ADDR, 8'ha5);
    wr(`ISI_OFS_CTRL0, 8'he3);
    for (int db = 0; db < 4; db++) begin
      wr(`ISI_OFS_CTRL1, 8'h02);
      wr(`ISI_OFS_SUBC, {2'b00, db[1:0], 4'h0});
      i_isi_master_model.start();
      i_isi_master_model.wr_byte(8'ha4, ack);
      chk("address ack", 32'h0, {31'h0, ack});
      rdm(`ISI_OFS_CTRL1, 8'he4, 8'he0, "flags on hit");
      chk("irq count", 2 * db + 1, irq_cnt);
      chk("wake count", db + 1, wake_cnt);
      axi_rd(`ISI_OFS_DATA, d, r);
      rdm(`ISI_OFS_CTRL1, 8'hc0, 8'h00, "flags released");
      wr(`ISI_OFS_CTRL1, {4'h0, db == 3, 3'h2});
      b = 8'h96 ^ 8'(db);
      i_isi_master_model.wr_byte(b, ack);
      chk("data ack", {31'h0, db == 3}, {31'h0, ack});
      rdm(`ISI_OFS_CTRL1, 8'he0, 8'ha0, "byte done");
      rdm(`ISI_OFS_DATA, 8'hff, b, "received byte");
      i_isi_master_model.stop();
      rdm(`ISI_OFS_CTRL1, 8'h20, 8'h00, "bus free");
    end
    wr(`ISI_OFS_CTRL1, 8'h00);
    i_isi_master_model.start();
    i_isi_master_model.wr_byte(8'ha6, ack);
    chk("foreign ack", 32'h1, {31'h0, ack});
    rdm(`ISI_OFS_CTRL1, 8'h40, 8'h00, "no hit");
    i_isi_master_model.stop();
    wr(`ISI_OFS_CTRL0, 8'he2);
    i_isi_master_model.start();
    i_isi_master_model.wr_byte(8'ha5, ack);
    rdm(`ISI_OFS_CTRL1, 8'he4, 8'he4, "read request");
    chk("masked irq", 32'd8, irq_cnt);
    chk("wake off", 32'd4, wake_cnt);
    wr(`ISI_OFS_CTRL1, 8'h10);
    wr(`ISI_OFS_DATA, 8'h3c);
    i_isi_master_model.rd_byte(1'b0, b);
    chk("first sent", 32'h3c, {24'h0, b});
    rdm(`ISI_OFS_CTRL1, 8'h81, 8'h80, "acked");
    wr(`ISI_OFS_DATA, 8'hc3);
    i_isi_master_model.rd_byte(1'b1, b);
    chk("last sent", 32'hc3, {24'h0, b});
    rdm(`ISI_OFS_CTRL1, 8'h01, 8'h01, "not acked");
    chk("data released", 32'h0, {31'h0, sda_oe});
    chk("open drain levels", 32'h0, {30'h0, scl_o, sda_o});
    i_isi_master_model.stop();
    rdm(`ISI_OFS_CTRL1, 8'h20, 8'h00, "bus free");
    summarize();
  end
endmodule
